// File: hdl/cip_interp.sv
// Purpose: servo drive command interpreter
// Assumes: commands arrive tokenised, one per handshake; one clock
// Notes: nonvolatile store is modelled as a two-generation memory
// What this block does
// - At power-on enter the mode held in initial-mode parameter; factory value is 29.
// - Legal mode codes: 29, 3, 21, 129, 131, 137, 139.
// - Step-train mode follows forward and backward pulse pins.
// - Absolute mode: target value is absolute; motion starts on target command only.
// - Mode changes keep accumulated position error; no displacement.
// - Moves of a revolution or more go the full amount without wrapping.
// - Relative mode: value adds to final target; motion starts on target command.
// - Jog forward at jog speed; velocity command changes it; halt stops.
// - Jog reverse at jog speed; velocity command changes it; halt stops.
// - Homing: jog speed, creep after switch edge, load origin on Z edge, stop.
// - Switch already on at start: move off opposite way, then search again.
// - Reverse homing is the forward sequence with directions inverted.
// - Echo command returns the last received mode, command and data.
// - Resend returns the last real reply, skipping any echo reply.
// - Parameter query replies with that parameter's working value.
// - Parameter write touches working copy only; unchangeable ones are not written.
// - Save stores working parameters into nonvolatile memory.
// - Load reads nonvolatile parameters into the working copy.
// - Prior load reads the previous nonvolatile generation.
// - Override mask resets to zero; a set bit lets serial control that function.
// - Mask bits: 0 servo, 1/2 inhibits, 5 brake, 6 alarm clear, 7 motion inhibit.
// - Mask all sets 255; single bits set by index and value.
`timescale 1ns/1ps
`include "cip_defs.svh"

module cip_interp (
	// Clock, reset, enable
	input wire clk_in,
	input wire rst_b_in,
	input wire ce_in,
	// Command stream
	input wire cmd_valid_in,
	input cip_pkg::cip_op_t cmd_op_in,
	input wire [4:0] cmd_idx_in,
	input wire [31:0] cmd_val_in,
	output logic cmd_ready_out,
	// Reply stream
	output logic rep_valid_out,
	output cip_pkg::cip_rep_t rep_kind_out,
	output cip_pkg::cip_op_t rep_op_out,
	output logic [4:0] rep_idx_out,
	output logic [31:0] rep_val_out,
	// Connector inputs
	input wire forward_pulse_pin_in,
	input wire backward_pulse_pin_in,
	input wire origin_limit_switch_in,
	input wire zphase_in,
	input wire [7:0] hw_ctrl_in,
	// Motion and control outputs
	output logic [7:0] mode_code_out,
	output logic [31:0] target_pos_out,
	output logic move_start_out,
	output logic signed [15:0] vel_cmd_out,
	output logic pos_load_out,
	output logic [31:0] pos_load_val_out,
	output logic [7:0] ctrl_out
);

	typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_QUERY, ST_COPY} cip_st_t;

	cip_st_t st_r;
	cip_st_t st_nxt;
	logic [5:0] cnt_r;
	logic [4:0] waddr_r;
	logic pend_r;
	logic save_r;
	logic bank_r;
	logic gen_r;
	logic take;
	logic is_copy;
	logic wk_we;
	logic [4:0] wk_wa;
	logic [31:0] wk_wd;
	logic [4:0] wk_ra;
	logic [31:0] wk_rd;
	logic nv_we;
	logic [31:0] nv_rd;
	logic [7:0] init_mode_r;
	logic [15:0] jog_r;
	logic [15:0] creep_r;
	logic [31:0] origin_r;
	logic [7:0] mode_r;
	logic [7:0] mode_nxt;
	logic [15:0] speed_r;
	logic halted_r;
	logic fwd_q;
	logic bwd_q;
	logic fwd_rise;
	logic bwd_rise;
	logic hstart;
	logic hhalt;
	logic signed [15:0] hom_vel;
	logic hom_load;
	logic [31:0] hom_val;
	logic [7:0] mask_r;
	logic [7:0] ser_r;
	cip_pkg::cip_op_t lrx_op_r;
	logic [4:0] lrx_idx_r;
	logic [31:0] lrx_val_r;
	cip_pkg::cip_op_t ltx_op_r;
	logic [4:0] ltx_idx_r;
	logic [31:0] ltx_val_r;

	// Parameter numbers the host may not change
	localparam logic [31:0] LOCKED_MAP = `CIP_LOCKED;

	// Factory parameter values
	function automatic logic [31:0] fact_val(input logic [4:0] idx);
		unique case (idx)
			`CIP_PN_INIT_MODE: return `CIP_FACT_INIT_MODE;
			`CIP_PN_JOG: return `CIP_FACT_JOG;
			`CIP_PN_CREEP: return `CIP_FACT_CREEP;
			`CIP_PN_ORIGIN: return `CIP_FACT_ORIGIN;
			default: return 32'h00000000;
		endcase
	endfunction : fact_val

	// Code names a known mode
	function automatic logic mode_ok(input logic [7:0] c);
		return c == `CIP_M_FOLLOW || c == `CIP_M_ABS || c == `CIP_M_REL ||
			c == `CIP_M_JOG_FWD || c == `CIP_M_JOG_REV ||
			c == `CIP_M_HOME_FWD || c == `CIP_M_HOME_REV;
	endfunction : mode_ok

	// Homing mode code
	function automatic logic is_home(input logic [7:0] c);
		return c == `CIP_M_HOME_FWD || c == `CIP_M_HOME_REV;
	endfunction : is_home

	assign take = cmd_valid_in & cmd_ready_out & ce_in;
	assign is_copy = cmd_op_in == cip_pkg::OP_SAVE || cmd_op_in == cip_pkg::OP_LOAD ||
		cmd_op_in == cip_pkg::OP_LOAD_PRIOR;
	assign fwd_rise = forward_pulse_pin_in & ~fwd_q;
	assign bwd_rise = backward_pulse_pin_in & ~bwd_q;
	assign mode_nxt = mode_ok(cmd_val_in[7:0]) ? cmd_val_in[7:0] : `CIP_M_FOLLOW;
	assign hstart = take && cmd_op_in == cip_pkg::OP_MODE && is_home(mode_nxt);
	assign hhalt = take && (cmd_op_in == cip_pkg::OP_HALT ||
		(cmd_op_in == cip_pkg::OP_MODE && !is_home(mode_nxt)));

	// Next sequencer state
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_INIT: if (cnt_r == `CIP_LAST_IDX) st_nxt = ST_IDLE;
			ST_IDLE: if (take) begin
				if (cmd_op_in == cip_pkg::OP_PQUERY)
					st_nxt = ST_QUERY;
				else if (is_copy)
					st_nxt = ST_COPY;
			end
			ST_QUERY: st_nxt = ST_IDLE;
			ST_COPY: if (pend_r && cnt_r == `CIP_COPY_END) st_nxt = ST_IDLE;
		endcase
	end

	// Sequencer: factory fill, query wait, parameter copy
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r <= ST_INIT;
			cnt_r <= 6'h00;
			pend_r <= 1'b0;
			waddr_r <= 5'h00;
			save_r <= 1'b0;
			bank_r <= 1'b0;
			gen_r <= 1'b0;
			cmd_ready_out <= 1'b0;
		end else if (ce_in) begin
			st_r <= st_nxt;
			cmd_ready_out <= st_nxt == ST_IDLE;
			pend_r <= 1'b0;
			if (st_r == ST_INIT) begin
				cnt_r <= cnt_r + 6'h01;
			end else if (st_r == ST_COPY) begin
				pend_r <= cnt_r < `CIP_COPY_END;
				waddr_r <= cnt_r[4:0];
				if (cnt_r < `CIP_COPY_END)
					cnt_r <= cnt_r + 6'h01;
				if (st_nxt == ST_IDLE && save_r)
					gen_r <= ~gen_r;
			end else if (take && is_copy) begin
				cnt_r <= 6'h00;
				save_r <= cmd_op_in == cip_pkg::OP_SAVE;
				bank_r <= (cmd_op_in == cip_pkg::OP_LOAD) ? gen_r : ~gen_r;
			end
		end
	end

	// Memory port steering
	always_comb begin
		wk_we = 1'b0;
		wk_wa = cnt_r[4:0];
		wk_wd = fact_val(cnt_r[4:0]);
		nv_we = 1'b0;
		if (st_r == ST_INIT) begin
			wk_we = 1'b1;
		end else if (st_r == ST_COPY && pend_r) begin
			wk_wa = waddr_r;
			wk_wd = nv_rd;
			wk_we = !save_r;
			nv_we = save_r;
		end else if (take && cmd_op_in == cip_pkg::OP_PWRITE &&
			!LOCKED_MAP[cmd_idx_in]) begin
			wk_we = 1'b1;
			wk_wa = cmd_idx_in;
			wk_wd = cmd_val_in;
		end
	end
	assign wk_ra = (st_r == ST_COPY) ? cnt_r[4:0] : cmd_idx_in;

	// Working parameter copy
	cip_pmem #(.AW(5), .DW(32)) u_work (
		.clk_in(clk_in),
		.ce_in(ce_in),
		.we_in(wk_we),
		.waddr_in(wk_wa),
		.wdata_in(wk_wd),
		.raddr_in(wk_ra),
		.rdata_out(wk_rd)
	);

	// Nonvolatile store, two generations
	cip_pmem #(.AW(6), .DW(32)) u_nv (
		.clk_in(clk_in),
		.ce_in(ce_in),
		.we_in(nv_we),
		.waddr_in({bank_r, waddr_r}),
		.wdata_in(wk_rd),
		.raddr_in({bank_r, cnt_r[4:0]}),
		.rdata_out(nv_rd)
	);

	// Shadows of parameters the motion logic uses
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			init_mode_r <= `CIP_M_FOLLOW;
			jog_r <= 16'h0000;
			creep_r <= 16'h0000;
			origin_r <= 32'h00000000;
		end else if (ce_in && wk_we) begin
			if (wk_wa == `CIP_PN_INIT_MODE)
				init_mode_r <= wk_wd[7:0];
			if (wk_wa == `CIP_PN_JOG)
				jog_r <= wk_wd[15:0];
			if (wk_wa == `CIP_PN_CREEP)
				creep_r <= wk_wd[15:0];
			if (wk_wa == `CIP_PN_ORIGIN)
				origin_r <= wk_wd;
		end
	end

	cip_homing u_home (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.ce_in(ce_in),
		.start_in(hstart),
		.reverse_in(mode_nxt == `CIP_M_HOME_REV),
		.abort_in(hhalt),
		.switch_in(origin_limit_switch_in),
		.zphase_in(zphase_in),
		.jog_in(jog_r),
		.creep_in(creep_r),
		.origin_in(origin_r),
		.vel_out(hom_vel),
		.load_out(hom_load),
		.load_val_out(hom_val)
	);

	// Mode, speed and target
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mode_r <= `CIP_M_FOLLOW;
			speed_r <= 16'h0000;
			halted_r <= 1'b0;
			target_pos_out <= 32'h00000000;
			move_start_out <= 1'b0;
			fwd_q <= 1'b0;
			bwd_q <= 1'b0;
		end else if (ce_in) begin
			fwd_q <= forward_pulse_pin_in;
			bwd_q <= backward_pulse_pin_in;
			move_start_out <= 1'b0;
			if (st_r == ST_INIT && st_nxt == ST_IDLE) begin
				mode_r <= mode_ok(init_mode_r) ? init_mode_r : `CIP_M_FOLLOW;
				speed_r <= jog_r;
			end
			// Target keeps running across mode changes
			if (mode_r == `CIP_M_FOLLOW && fwd_rise != bwd_rise) begin
				target_pos_out <= fwd_rise ? target_pos_out + 32'h00000001
					: target_pos_out - 32'h00000001;
			end
			if (take) begin
				unique case (cmd_op_in)
					cip_pkg::OP_MODE: begin
						mode_r <= mode_nxt;
						speed_r <= jog_r;
						halted_r <= 1'b0;
					end
					cip_pkg::OP_VELOCITY: speed_r <= cmd_val_in[15:0];
					cip_pkg::OP_HALT: halted_r <= 1'b1;
					cip_pkg::OP_TARGET: if (mode_r == `CIP_M_ABS) begin
						target_pos_out <= cmd_val_in;
						move_start_out <= 1'b1;
						halted_r <= 1'b0;
					end else if (mode_r == `CIP_M_REL) begin
						target_pos_out <= target_pos_out + cmd_val_in;
						move_start_out <= 1'b1;
						halted_r <= 1'b0;
					end
					default: ;
				endcase
			end
		end
	end
	assign mode_code_out = mode_r;

	// Velocity command and origin load
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			vel_cmd_out <= 16'sh0000;
			pos_load_out <= 1'b0;
			pos_load_val_out <= 32'h00000000;
		end else if (ce_in) begin
			pos_load_out <= hom_load;
			pos_load_val_out <= hom_val;
			if (is_home(mode_r))
				vel_cmd_out <= hom_vel;
			else if (halted_r || mode_r == `CIP_M_FOLLOW)
				vel_cmd_out <= 16'sh0000;
			else if (mode_r == `CIP_M_JOG_REV)
				vel_cmd_out <= -$signed(speed_r);
			else
				vel_cmd_out <= $signed(speed_r);
		end
	end

	// Override mask and serial control bits
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mask_r <= `CIP_MASK_RST;
			ser_r <= 8'h00;
			ctrl_out <= 8'h00;
		end else if (ce_in) begin
			ctrl_out <= (hw_ctrl_in & ~mask_r) | (ser_r & mask_r);
			if (take) begin
				unique case (cmd_op_in)
					cip_pkg::OP_MASK_WRITE: mask_r <= cmd_val_in[7:0];
					cip_pkg::OP_MASK_ALL: mask_r <= `CIP_MASK_ALL;
					cip_pkg::OP_MASK_BIT: mask_r[cmd_idx_in[2:0]] <= cmd_val_in[0];
					cip_pkg::OP_SERIAL_CTRL: ser_r[cmd_idx_in[2:0]] <= cmd_val_in[0];
					default: ;
				endcase
			end
		end
	end

	// Replies and the received and sent history
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rep_valid_out <= 1'b0;
			rep_kind_out <= cip_pkg::REP_VALUE;
			rep_op_out <= cip_pkg::OP_MODE;
			rep_idx_out <= 5'h00;
			rep_val_out <= 32'h00000000;
			lrx_op_r <= cip_pkg::OP_MODE;
			lrx_idx_r <= 5'h00;
			lrx_val_r <= 32'h00000000;
			ltx_op_r <= cip_pkg::OP_MODE;
			ltx_idx_r <= 5'h00;
			ltx_val_r <= 32'h00000000;
		end else if (ce_in) begin
			rep_valid_out <= 1'b0;
			if (take && cmd_op_in != cip_pkg::OP_ECHO && cmd_op_in != cip_pkg::OP_RESEND) begin
				lrx_op_r <= cmd_op_in;
				lrx_idx_r <= cmd_idx_in;
				lrx_val_r <= cmd_val_in;
			end
			if (take && cmd_op_in == cip_pkg::OP_ECHO) begin
				rep_valid_out <= 1'b1;
				rep_kind_out <= cip_pkg::REP_ECHO;
				rep_op_out <= lrx_op_r;
				rep_idx_out <= lrx_idx_r;
				rep_val_out <= lrx_val_r;
			end else if (take && cmd_op_in == cip_pkg::OP_RESEND) begin
				rep_valid_out <= 1'b1;
				rep_kind_out <= cip_pkg::REP_VALUE;
				rep_op_out <= ltx_op_r;
				rep_idx_out <= ltx_idx_r;
				rep_val_out <= ltx_val_r;
			end else if (st_r == ST_QUERY) begin
				rep_valid_out <= 1'b1;
				rep_kind_out <= cip_pkg::REP_VALUE;
				rep_op_out <= cip_pkg::OP_PQUERY;
				rep_idx_out <= lrx_idx_r;
				rep_val_out <= wk_rd;
				ltx_op_r <= cip_pkg::OP_PQUERY;
				ltx_idx_r <= lrx_idx_r;
				ltx_val_r <= wk_rd;
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_take(cip_pkg::cip_op_t op);
		take && cmd_op_in == op;
	endsequence

	a_boot_mode: assert property ((st_r == ST_INIT) ##1 (st_r == ST_IDLE) |-> mode_r == init_mode_r)
		else $error("power-on mode not from parameter");
	a_mode_legal: assert property (mode_ok(mode_r))
		else $error("illegal mode code");
	a_follow_step: assert property ((ce_in && mode_r == `CIP_M_FOLLOW && fwd_rise && !bwd_rise)
		|=> target_pos_out == $past(target_pos_out) + 32'h00000001)
		else $error("step not followed");
	a_abs_target: assert property ((s_take(cip_pkg::OP_TARGET) and mode_r == `CIP_M_ABS)
		|=> target_pos_out == $past(cmd_val_in) && move_start_out)
		else $error("absolute target wrong");
	a_mode_keeps: assert property ((s_take(cip_pkg::OP_MODE) and !fwd_rise && !bwd_rise)
		|=> target_pos_out == $past(target_pos_out) && !move_start_out)
		else $error("mode change moved target");
	a_rel_target: assert property ((s_take(cip_pkg::OP_TARGET) and mode_r == `CIP_M_REL)
		|=> target_pos_out == $past(target_pos_out) + $past(cmd_val_in))
		else $error("relative target wrong");
	a_jog_speed: assert property ((s_take(cip_pkg::OP_MODE) and mode_nxt == `CIP_M_JOG_FWD)
		##1 ce_in |=> vel_cmd_out == $signed(jog_r))
		else $error("jog speed wrong");
	a_halt_stops: assert property ((s_take(cip_pkg::OP_HALT) and !is_home(mode_r))
		##1 ce_in |=> vel_cmd_out == 16'sh0000)
		else $error("halt did not stop");
	a_echo_reply: assert property (s_take(cip_pkg::OP_ECHO)
		|=> rep_valid_out && rep_kind_out == cip_pkg::REP_ECHO && rep_op_out == $past(lrx_op_r))
		else $error("echo wrong");
	a_resend_reply: assert property (s_take(cip_pkg::OP_RESEND)
		|=> rep_valid_out && rep_kind_out == cip_pkg::REP_VALUE && rep_val_out == $past(ltx_val_r))
		else $error("resend wrong");
	a_query_reply: assert property (s_take(cip_pkg::OP_PQUERY) ##1 ce_in
		|=> rep_valid_out && rep_idx_out == $past(cmd_idx_in, 2))
		else $error("query reply missing");
	a_nv_only_save: assert property (nv_we |-> st_r == ST_COPY && save_r)
		else $error("nonvolatile written outside save");
	a_copy_ends: assert property (s_take(cip_pkg::OP_SAVE)
		|=> st_r == ST_COPY ##[30:40] cmd_ready_out)
		else $error("save did not finish");
	a_prior_bank: assert property (s_take(cip_pkg::OP_LOAD_PRIOR) |=> bank_r == !gen_r)
		else $error("prior load bank wrong");
	a_mask_all: assert property (s_take(cip_pkg::OP_MASK_ALL) |=> mask_r == `CIP_MASK_ALL)
		else $error("mask all not set");
	a_busy_order: assert property ((st_r != ST_IDLE) |-> !take)
		else $error("command taken while busy");

endmodule : cip_interp

// File: inc/cip_defs.svh
// Purpose: constants of the servo command interpreter
// Assumes: 32 working parameters of 32 bits
// Notes: mode codes are the values held in the initial-mode parameter
`ifndef CIP_DEFS_SVH
`define CIP_DEFS_SVH

// Parameter table
`define CIP_LAST_IDX 6'h1f
`define CIP_COPY_END 6'h20
`define CIP_PN_INIT_MODE 5'h0c
`define CIP_PN_JOG 5'h17
`define CIP_PN_CREEP 5'h18
`define CIP_PN_ORIGIN 5'h1d
`define CIP_LOCKED 32'h0000056f

// Factory values
`define CIP_FACT_INIT_MODE 32'h0000001d
`define CIP_FACT_JOG 32'h0000000a
`define CIP_FACT_CREEP 32'h00000002
`define CIP_FACT_ORIGIN 32'h00000000

// Mode codes
`define CIP_M_FOLLOW 8'h1d
`define CIP_M_ABS 8'h03
`define CIP_M_REL 8'h15
`define CIP_M_JOG_FWD 8'h81
`define CIP_M_JOG_REV 8'h83
`define CIP_M_HOME_FWD 8'h89
`define CIP_M_HOME_REV 8'h8b

// Override mask
`define CIP_MASK_RST 8'h00
`define CIP_MASK_ALL 8'hff

`endif

// File: inc/cip_pkg.sv
// Purpose: types shared by the interpreter and its bench
// Assumes: commands arrive already tokenised
// Notes: none
package cip_pkg;

	// Command operations
	typedef enum logic [3:0] {
		OP_MODE, OP_TARGET, OP_VELOCITY, OP_HALT,
		OP_ECHO, OP_RESEND, OP_PQUERY, OP_PWRITE,
		OP_SAVE, OP_LOAD, OP_LOAD_PRIOR,
		OP_MASK_WRITE, OP_MASK_BIT, OP_MASK_ALL, OP_SERIAL_CTRL
	} cip_op_t;

	// Reply kinds
	typedef enum logic {REP_VALUE, REP_ECHO} cip_rep_t;

endpackage : cip_pkg

// File: hdl/cip_pmem.sv
// Purpose: parameter word memory with registered read
// Assumes: one write and one read port
// Notes: read during write returns the old word
`timescale 1ns/1ps

module cip_pmem #(
	parameter int AW = 5,
	parameter int DW = 32
) (
	// Clock and enable
	input wire clk_in,
	input wire ce_in,
	// Write port
	input wire we_in,
	input wire [AW-1:0] waddr_in,
	input wire [DW-1:0] wdata_in,
	// Read port
	input wire [AW-1:0] raddr_in,
	output logic [DW-1:0] rdata_out
);

	logic [DW-1:0] mem_r [0:(1<<AW)-1];

	// Storage and read register
	always_ff @(posedge clk_in) begin
		if (ce_in) begin
			if (we_in)
				mem_r[waddr_in] <= wdata_in;
			rdata_out <= mem_r[raddr_in];
		end
	end

endmodule : cip_pmem

// File: hdl/cip_homing.sv
// Purpose: origin search sequencer
// Assumes: switch and Z-phase inputs synchronous to clk_in
// Notes: a stop here is velocity zero; the profile outside decelerates
`timescale 1ns/1ps

module cip_homing (
	// Clock, reset, enable
	input wire clk_in,
	input wire rst_b_in,
	input wire ce_in,
	// Control
	input wire start_in,
	input wire reverse_in,
	input wire abort_in,
	// Sensors
	input wire switch_in,
	input wire zphase_in,
	// Parameters
	input wire [15:0] jog_in,
	input wire [15:0] creep_in,
	input wire [31:0] origin_in,
	// Results
	output logic signed [15:0] vel_out,
	output logic load_out,
	output logic [31:0] load_val_out
);

	typedef enum logic [2:0] {H_IDLE, H_ESCAPE, H_SEEK, H_CREEP, H_STOP} cip_hst_t;

	cip_hst_t st_r;
	logic rev_r;
	logic sw_q;
	logic z_q;
	logic sw_rise;
	logic z_rise;

	// Signed speed toward a direction
	function automatic logic signed [15:0] dirv(input logic backward_pulse_pin, input logic [15:0] mag);
		logic signed [15:0] m;
		m = $signed(mag);
		return backward_pulse_pin ? -m : m;
	endfunction : dirv

	assign sw_rise = switch_in & ~sw_q;
	assign z_rise = zphase_in & ~z_q;

	// Edge history
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sw_q <= 1'b0;
			z_q <= 1'b0;
		end else if (ce_in) begin
			sw_q <= switch_in;
			z_q <= zphase_in;
		end
	end

	// Search sequence
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r <= H_IDLE;
			rev_r <= 1'b0;
			vel_out <= 16'sh0000;
			load_out <= 1'b0;
			load_val_out <= 32'h00000000;
		end else if (ce_in) begin
			load_out <= 1'b0;
			if (abort_in) begin
				st_r <= H_IDLE;
				vel_out <= 16'sh0000;
			end else begin
				unique case (st_r)
					H_IDLE: if (start_in) begin
						rev_r <= reverse_in;
						if (switch_in) begin
							st_r <= H_ESCAPE;
							vel_out <= dirv(!reverse_in, jog_in);
						end else begin
							st_r <= H_SEEK;
							vel_out <= dirv(reverse_in, jog_in);
						end
					end
					H_ESCAPE: if (!switch_in) begin
						st_r <= H_SEEK;
						vel_out <= dirv(rev_r, jog_in);
					end
					H_SEEK: if (sw_rise) begin
						st_r <= H_CREEP;
						vel_out <= dirv(rev_r, creep_in);
					end
					H_CREEP: if (z_rise) begin
						st_r <= H_STOP;
						load_out <= 1'b1;
						load_val_out <= origin_in;
						vel_out <= 16'sh0000;
					end
					H_STOP: st_r <= H_IDLE;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_edge_seen;
		st_r == H_SEEK && sw_rise && !abort_in && ce_in;
	endsequence

	a_creep_on_edge: assert property (s_edge_seen |=> vel_out == dirv(rev_r, creep_in))
		else $error("creep speed not taken on switch edge");
	a_origin_load: assert property ((st_r == H_CREEP && z_rise && !abort_in && ce_in)
		|=> load_out && load_val_out == $past(origin_in) && vel_out == 16'sh0000)
		else $error("origin not loaded on Z edge");
	a_escape_first: assert property ((st_r == H_IDLE && start_in && switch_in && !abort_in && ce_in)
		|=> st_r == H_ESCAPE && (vel_out < 0) == !$past(reverse_in))
		else $error("escape not opposite to search");
	a_search_dir: assert property ((st_r == H_SEEK && vel_out != 16'sh0000) |-> (vel_out < 0) == rev_r)
		else $error("search direction wrong");

endmodule : cip_homing

// File: verification/cip_host.sv
// Purpose: host model driving tokenised commands
// Assumes: one command per handshake
// Notes: released index and value lines show inverted data
`timescale 1ns/1ps
`include "cip_defs.svh"

module cip_host (
	// Clock
	input wire clk_in,
	// Command stream
	input wire cmd_ready_in,
	output logic cmd_valid_out,
	output cip_pkg::cip_op_t cmd_op_out,
	output logic [4:0] cmd_idx_out,
	output logic [31:0] cmd_val_out
);
	// Idle bus at time zero
	initial begin
		cmd_valid_out = 1'b0;
		cmd_op_out = cip_pkg::OP_MODE;
		cmd_idx_out = 5'h00;
		cmd_val_out = 32'h0;
	end
	// Offer one command, except a write to a locked parameter, and hold it until taken
	task automatic send(input cip_pkg::cip_op_t op, input logic [4:0] idx,
		input logic [31:0] val);
		logic [31:0] lk;
		lk = `CIP_LOCKED;
		if (op == cip_pkg::OP_PWRITE && lk[idx]) return;
		@(negedge clk_in);
		cmd_valid_out = 1'b1;
		cmd_op_out = op;
		cmd_idx_out = idx;
		cmd_val_out = val;
		// Ready is settled at the falling edge; take follows at the next rising edge
		while (cmd_ready_in !== 1'b1) @(negedge clk_in);
		@(posedge clk_in);
		@(negedge clk_in);
		cmd_valid_out = 1'b0;
		cmd_idx_out = ~idx;
		cmd_val_out = ~val;
	endtask : send
endmodule : cip_host

// File: verification/testbench.sv
// Purpose: self-checking bench of the command interpreter
// Assumes: clock enable held high
// Notes: host model issues every command
`timescale 1ns/1ps

module testbench;
	logic clk_in, rst_b_in, sw, zp, cmd_valid, cmd_ready, rep_valid, mv, pl, fp, bp;
	logic [4:0] cmd_idx, rep_idx;
	logic [7:0] hw, mode, ctrl;
	logic [31:0] cmd_val, rep_val, tgt, lval;
	logic signed [15:0] vel;
	cip_pkg::cip_op_t cmd_op, rep_op;
	cip_pkg::cip_rep_t rep_kind;
	int miscompares = 0, cmp_count = 0, cycles = 0, starts = 0, replies = 0;
	logic [7:0] codes [7] = '{8'h1d, 8'h03, 8'h15, 8'h81, 8'h83, 8'h89, 8'h8b};

	cip_host i_cip_host (.clk_in(clk_in), .cmd_ready_in(cmd_ready),
		.cmd_valid_out(cmd_valid), .cmd_op_out(cmd_op), .cmd_idx_out(cmd_idx),
		.cmd_val_out(cmd_val));
	cip_interp i_cip_interp (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
		.cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_idx_in(cmd_idx),
		.cmd_val_in(cmd_val), .cmd_ready_out(cmd_ready), .rep_valid_out(rep_valid),
		.rep_kind_out(rep_kind), .rep_op_out(rep_op), .rep_idx_out(rep_idx),
		.rep_val_out(rep_val), .forward_pulse_pin_in(fp),
		.backward_pulse_pin_in(bp), .origin_limit_switch_in(sw), .zphase_in(zp),
		.hw_ctrl_in(hw), .mode_code_out(mode), .target_pos_out(tgt),
		.move_start_out(mv), .vel_cmd_out(vel), .pos_load_out(pl),
		.pos_load_val_out(lval), .ctrl_out(ctrl));

	// Clock and cycle ceiling
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Tally one-cycle pulses between edges
	always @(negedge clk_in) begin
		starts += mv;
		replies += rep_valid;
	end

	// Issue one command, let its effects land, wait for ready
	task automatic run(input cip_pkg::cip_op_t op, input logic [4:0] idx,
		input logic [31:0] val);
		i_cip_host.send(op, idx, val);
		repeat (3) @(negedge clk_in);
		for (int n = 0; n < 60 && cmd_ready !== 1'b1; n++) @(negedge clk_in);
	endtask : run

	task automatic t_reset();
		repeat (40) @(negedge clk_in);
		check(mode, 32'h1d);
		check(ctrl, hw);
		run(cip_pkg::OP_PQUERY, 5'h0c, 0);
		check(rep_val, 32'h1d);
	endtask : t_reset

	task automatic t_follow();
		repeat (3) begin
			fp = 1'b1;
			@(negedge clk_in);
			fp = 1'b0;
			@(negedge clk_in);
		end
		{fp, bp} = 2'b11;
		@(negedge clk_in);
		{fp, bp} = 2'b00;
		@(negedge clk_in);
		bp = 1'b1;
		@(negedge clk_in);
		bp = 1'b0;
		@(negedge clk_in);
		check(tgt, 32'h2);
	endtask : t_follow

	task automatic t_modes();
		foreach (codes[i]) begin
			run(cip_pkg::OP_MODE, 0, codes[i]);
			check(mode, codes[i]);
		end
	endtask : t_modes

	task automatic t_jog();
		run(cip_pkg::OP_MODE, 0, 32'h81);
		check(vel, 32'ha);
		run(cip_pkg::OP_VELOCITY, 0, 32'h5);
		check(vel, 32'h5);
		run(cip_pkg::OP_HALT, 0, 0);
		check(vel, 32'h0);
		run(cip_pkg::OP_MODE, 0, 32'h83);
		check(32'(vel), 32'hfffffff6);
	endtask : t_jog

	task automatic t_pos();
		run(cip_pkg::OP_MODE, 0, 32'h03);
		run(cip_pkg::OP_TARGET, 0, 32'h64);
		check(tgt, 32'h64);
		run(cip_pkg::OP_TARGET, 0, 32'h500000);
		check(tgt, 32'h500000);
		run(cip_pkg::OP_MODE, 0, 32'h15);
		check(tgt, 32'h500000);
		run(cip_pkg::OP_TARGET, 0, 32'h32);
		check(tgt, 32'h500032);
		check(starts, 32'h3);
	endtask : t_pos

	task automatic t_params();
		run(cip_pkg::OP_PWRITE, 5'h17, 32'h7);
		run(cip_pkg::OP_SAVE, 0, 0);
		run(cip_pkg::OP_PWRITE, 5'h17, 32'h9);
		run(cip_pkg::OP_PQUERY, 5'h17, 0);
		check(rep_val, 32'h9);
		run(cip_pkg::OP_SAVE, 0, 0);
		run(cip_pkg::OP_LOAD_PRIOR, 0, 0);
		run(cip_pkg::OP_PQUERY, 5'h17, 0);
		check(rep_val, 32'h7);
		run(cip_pkg::OP_LOAD, 0, 0);
		run(cip_pkg::OP_PQUERY, 5'h17, 0);
		check(rep_val, 32'h9);
		run(cip_pkg::OP_ECHO, 0, 0);
		check({rep_kind, rep_op, rep_idx}, {cip_pkg::REP_ECHO, cip_pkg::OP_PQUERY, 5'h17});
		run(cip_pkg::OP_RESEND, 0, 0);
		check(rep_kind, cip_pkg::REP_VALUE);
		check(rep_val, 32'h9);
		check(replies, 32'h6);
	endtask : t_params

	task automatic t_mask();
		hw = 8'h00;
		run(cip_pkg::OP_MASK_BIT, 5'h7, 32'h1);
		run(cip_pkg::OP_SERIAL_CTRL, 5'h7, 32'h1);
		check(ctrl, 32'h80);
		hw = 8'h7e;
		run(cip_pkg::OP_MASK_ALL, 0, 0);
		run(cip_pkg::OP_SERIAL_CTRL, 5'h0, 32'h1);
		check(ctrl, 32'h81);
		run(cip_pkg::OP_MASK_WRITE, 0, 32'h0f);
		check(ctrl, 32'h71);
	endtask : t_mask

	task automatic t_home();
		run(cip_pkg::OP_PWRITE, 5'h1d, 32'h1234);
		run(cip_pkg::OP_MODE, 0, 32'h89);
		check(vel, 32'h9);
		sw = 1'b1;
		repeat (3) @(negedge clk_in);
		check(vel, 32'h2);
		zp = 1'b1;
		for (int n = 0; n < 6 && pl !== 1'b1; n++) @(negedge clk_in);
		check(pl, 32'h1);
		check(lval, 32'h1234);
		zp = 1'b0;
		run(cip_pkg::OP_MODE, 0, 32'h8b);
		check(vel, 32'h9);
	endtask : t_home

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up

	// Reset then scenarios
	initial begin
		rst_b_in = 1'b0;
		sw = 1'b0;
		zp = 1'b0;
		hw = 8'h5a;
		fp = 1'b0;
		bp = 1'b0;
		repeat (2) @(negedge clk_in);
		rst_b_in = 1'b1;
		t_reset();
		t_follow();
		t_modes();
		t_jog();
		t_pos();
		t_params();
		t_mask();
		t_home();
		wrap_up();
	end
endmodule : testbench
